// >>> pm_pkg.sv
// shared constants and types for the power mode controller
// assumes a 125 MHz core clock and an AXI4-Lite register port
package pm_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] POWER_CONTROL_IDX = 8'h87;
	localparam logic [7:0] SLOW_CTRL_IDX     = 8'hAD;
	localparam logic [7:0] CLOCK_STOP_IDX    = 8'hB6;
	localparam logic [7:0] STATUS_IDX        = 8'hC0;
	// field positions
	localparam int IDLE_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam int HALT_BIT = 1;
	localparam int BUSY_BIT = 4;
	// values after reset
	localparam logic [1:0]  POWER_CONTROL_RST = 2'h0;
	localparam logic [3:0]  SLOW_CTRL_RST     = 4'h0;
	localparam logic [15:0] RESET_VECTOR      = 16'h0000;
	// startup counts: slow oscillator cycles, then crystal cycles
	localparam logic [3:0] POR_SLOW   = 4'hE;
	localparam logic [3:0] WDOG_SLOW  = 4'hC;
	localparam logic [5:0] RESET_XTAL = 6'h18;
	localparam logic [3:0] PIN_SLOW   = 4'h3;
	localparam logic [3:0] TIMER_SLOW = 4'h3;
	localparam logic [5:0] WAKE_XTAL  = 6'h34;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic wdog;
		logic timer;
		logic pin1;
		logic pin0;
	} wake_s;

	typedef enum logic [3:0] {
		ST_BOOT,
		ST_RESET_WAIT,
		ST_RUN,
		ST_IDLE,
		ST_STOP,
		ST_SHUTDOWN,
		ST_POWER_DOWN,
		ST_WAKE
	} pm_state_e;
endpackage

// >>> sync3.sv
// three-stage synchroniser with agreement filter
// assumes inputs are asynchronous to clk
`timescale 1ns/10ps
module sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] ff1;
	logic [W-1:0] ff2;
	logic [W-1:0] ff3;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ff1 <= '0;
			ff2 <= '0;
			ff3 <= '0;
		end else begin
			ff1 <= din;
			ff2 <= ff1;
			ff3 <= ff2;
		end
	end

	// a bit changes only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (ff2[i] == ff3[i]) begin
					dout[i] <= ff3[i];
				end
			end
		end
	end
endmodule

// >>> startup_timer.sv
// startup delay: slow oscillator ticks, then crystal cycles
// assumes slow_tick is a one-cycle pulse on clk
`timescale 1ns/10ps
module startup_timer (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [3:0] slow_load,
	input  wire logic [5:0] xtal_load,
	input  wire logic       slow_tick,
	output logic            done
);
	logic [3:0] slow_left;
	logic [5:0] xtal_left;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_left <= 4'h0;
			xtal_left <= 6'h00;
		end else if (load) begin
			slow_left <= slow_load;
			xtal_left <= xtal_load;
		end else if (slow_left != 4'h0) begin
			if (slow_tick) begin
				slow_left <= slow_left - 4'h1;
			end
		end else if (xtal_left != 6'h00) begin
			xtal_left <= xtal_left - 6'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else begin
			done <= !load && slow_left == 4'h0 && xtal_left == 6'h01;
		end
	end
endmodule

// >>> power_mode_control.sv
// power mode controller: idle, stop and power-down with wake and reset sequencing
// assumes the core pulses instr_done at each instruction end and holds while cpu_hold
// Overview of operation
// - idle bit set enters idle only after the setting instruction completes.
// - idle suspends processing, keeps state, core clock keeps running.
// - enabled interrupt clears idle bit, leaves idle, core resumes after return.
// - watchdog in idle ends it, resets registers, restarts from vector zero.
// - stop bit set enters stop after the setting instruction completes.
// - stop is idle without interrupt exit; only watchdog reset leaves it.
// - clock halt bit set enters power-down after the instruction completes.
// - power-down keeps state, shuts clock then regulators in order.
// - power-down exits only on enabled low pin, timer wake or watchdog.
// - valid wake clears the clock halt bit in hardware.
// - interrupt tied to the wake runs right after clocks return.
// - watchdog in power-down ends it, resets registers, restarts at zero.
// - pin interrupt path off while powered down, wake path off while up.
// - pin wake is also captured for interrupt, held after pin returns high.
// - restart is 14 or 12 slow cycles then 24 crystal cycles.
// - wake takes 3 slow cycles plus at most 52 crystal cycles.
// - slow domain control register shows a read-only busy flag in bit 4.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module power_mode_control (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [11:0]       awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [11:0]       araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              instr_done,
	input  wire logic              irq_pending,
	input  wire logic [1:0]        irq_ack,
	input  wire pm_pkg::wake_s     wake_raw,
	input  wire logic [1:0]        port0_alt_function,
	input  wire logic              slow_wake_oscillator,
	input  wire logic              slow_busy,
	output logic                   cpu_hold,
	output logic                   cpu_reset,
	output logic [15:0]            reset_vector,
	output logic                   core_clk_en,
	output logic                   regulator_en,
	output logic                   irq_path_en,
	output logic                   wake_path_en,
	output logic [1:0]             pin_irq_capture,
	output logic [3:0]             slow_domain_control_reg
);
	pm_pkg::pm_state_e state;
	pm_pkg::pm_state_e next_state;
	pm_pkg::wake_s     wake;
	pm_pkg::wake_s     last_wake;
	logic              slow_lvl;
	logic              slow_lvl_d;
	logic              slow_tick;
	logic              busy;
	logic              wdog_d;
	logic              wdog_rise;
	logic [1:0]        pin_wake;
	logic              wake_ok;
	logic              timer_load;
	logic [3:0]        load_slow;
	logic [5:0]        load_xtal;
	logic              timer_done;
	logic [1:0]        power_control_reg;
	logic              clock_stop_reg;
	logic              wr_go;
	logic [7:0]        wr_idx;
	logic [7:0]        rd_idx;

	sync3 #(.W(6)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   ({slow_busy, slow_wake_oscillator, wake_raw}),
		.dout  ({busy, slow_lvl, wake})
	);

	startup_timer u_timer (
		.clk       (clk),
		.rst_n     (rst_n),
		.load      (timer_load),
		.slow_load (load_slow),
		.xtal_load (load_xtal),
		.slow_tick (slow_tick),
		.done      (timer_done)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_lvl_d <= 1'b0;
			wdog_d     <= 1'b0;
		end else begin
			slow_lvl_d <= slow_lvl;
			wdog_d     <= wake.wdog;
		end
	end

	assign slow_tick = slow_lvl && !slow_lvl_d;
	assign wdog_rise = wake.wdog && !wdog_d;
	assign pin_wake  = ~{wake.pin1, wake.pin0} & port0_alt_function;
	assign wake_ok   = wake.timer || (pin_wake != 2'b00);

	// mode sequencing
	always_comb begin
		next_state = state;
		timer_load = 1'b0;
		load_slow  = pm_pkg::POR_SLOW;
		load_xtal  = pm_pkg::RESET_XTAL;
		if (wdog_rise && state != pm_pkg::ST_BOOT) begin
			next_state = pm_pkg::ST_RESET_WAIT;
			timer_load = 1'b1;
			load_slow  = pm_pkg::WDOG_SLOW;
		end else begin
			case (state)
				pm_pkg::ST_BOOT: begin
					next_state = pm_pkg::ST_RESET_WAIT;
					timer_load = 1'b1;
				end
				pm_pkg::ST_RESET_WAIT: begin
					if (timer_done) begin
						next_state = pm_pkg::ST_RUN;
					end
				end
				pm_pkg::ST_RUN: begin
					if (instr_done) begin
						if (clock_stop_reg) begin
							next_state = pm_pkg::ST_SHUTDOWN;
						end else if (power_control_reg[pm_pkg::STOP_BIT]) begin
							next_state = pm_pkg::ST_STOP;
						end else if (power_control_reg[pm_pkg::IDLE_BIT]) begin
							next_state = pm_pkg::ST_IDLE;
						end
					end
				end
				pm_pkg::ST_IDLE: begin
					if (irq_pending) begin
						next_state = pm_pkg::ST_RUN;
					end
				end
				pm_pkg::ST_STOP: begin
					next_state = pm_pkg::ST_STOP;
				end
				pm_pkg::ST_SHUTDOWN: begin
					next_state = pm_pkg::ST_POWER_DOWN;
				end
				pm_pkg::ST_POWER_DOWN: begin
					if (wake_ok) begin
						next_state = pm_pkg::ST_WAKE;
						timer_load = 1'b1;
						load_xtal  = pm_pkg::WAKE_XTAL;
						load_slow  = wake.timer ? pm_pkg::TIMER_SLOW : pm_pkg::PIN_SLOW;
					end
				end
				pm_pkg::ST_WAKE: begin
					if (timer_done) begin
						next_state = pm_pkg::ST_RUN;
					end
				end
				default: begin
					next_state = pm_pkg::ST_BOOT;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= pm_pkg::ST_BOOT;
		end else begin
			state <= next_state;
		end
	end

	// core and supply controls, registered from the next state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_hold     <= 1'b1;
			cpu_reset    <= 1'b1;
			reset_vector <= pm_pkg::RESET_VECTOR;
			core_clk_en  <= 1'b0;
			regulator_en <= 1'b1;
			irq_path_en  <= 1'b1;
			wake_path_en <= 1'b0;
		end else begin
			cpu_hold     <= next_state != pm_pkg::ST_RUN;
			cpu_reset    <= next_state == pm_pkg::ST_RESET_WAIT || next_state == pm_pkg::ST_BOOT;
			reset_vector <= pm_pkg::RESET_VECTOR;
			core_clk_en  <= next_state != pm_pkg::ST_SHUTDOWN
				&& next_state != pm_pkg::ST_POWER_DOWN
				&& next_state != pm_pkg::ST_WAKE;
			regulator_en <= next_state != pm_pkg::ST_POWER_DOWN;
			irq_path_en  <= next_state != pm_pkg::ST_POWER_DOWN;
			wake_path_en <= next_state == pm_pkg::ST_POWER_DOWN;
		end
	end

	// pin wake kept for the interrupt logic until it acknowledges or a watchdog reset clears it; set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_irq_capture <= 2'b00;
		end else if (wdog_rise) begin
			pin_irq_capture <= 2'b00;
		end else if (state == pm_pkg::ST_POWER_DOWN) begin
			pin_irq_capture <= (pin_irq_capture & ~irq_ack) | pin_wake;
		end else begin
			pin_irq_capture <= pin_irq_capture & ~irq_ack;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_wake <= '0;
		end else if (wdog_rise) begin
			last_wake <= '{wdog: 1'b1, timer: 1'b0, pin1: 1'b0, pin0: 1'b0};
		end else if (state == pm_pkg::ST_POWER_DOWN && wake_ok) begin
			last_wake <= '{wdog: 1'b0, timer: wake.timer, pin1: pin_wake[1], pin0: pin_wake[0]};
		end
	end

	// write channel: address and data taken together
	assign awready = awvalid && wvalid && !bvalid;
	assign wready  = awready;
	assign wr_go   = awready;
	assign wr_idx  = awaddr[9:2];
	assign arready = !rvalid;
	assign rd_idx  = araddr[9:2];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_control_reg       <= pm_pkg::POWER_CONTROL_RST;
			clock_stop_reg          <= 1'b0;
			slow_domain_control_reg <= pm_pkg::SLOW_CTRL_RST;
		end else if (wdog_rise) begin
			power_control_reg       <= pm_pkg::POWER_CONTROL_RST;
			clock_stop_reg          <= 1'b0;
			slow_domain_control_reg <= pm_pkg::SLOW_CTRL_RST;
		end else if (state == pm_pkg::ST_IDLE && irq_pending) begin
			power_control_reg[pm_pkg::IDLE_BIT] <= 1'b0;
		end else if (state == pm_pkg::ST_POWER_DOWN && wake_ok) begin
			clock_stop_reg <= 1'b0;
		end else if (wr_go && wstrb[0] && awaddr[11:10] == 2'b00) begin
			if (wr_idx == pm_pkg::POWER_CONTROL_IDX) begin
				power_control_reg <= wdata[1:0];
			end else if (wr_idx == pm_pkg::CLOCK_STOP_IDX) begin
				clock_stop_reg <= wdata[pm_pkg::HALT_BIT];
			end else if (wr_idx == pm_pkg::SLOW_CTRL_IDX) begin
				slow_domain_control_reg <= wdata[3:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp  <= pm_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			if (awaddr[11:10] == 2'b00 && (wr_idx == pm_pkg::POWER_CONTROL_IDX
				|| wr_idx == pm_pkg::CLOCK_STOP_IDX || wr_idx == pm_pkg::SLOW_CTRL_IDX
				|| wr_idx == pm_pkg::STATUS_IDX)) begin
				bresp <= pm_pkg::RESP_OKAY;
			end else begin
				bresp <= pm_pkg::RESP_SLVERR;
			end
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= pm_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= pm_pkg::RESP_OKAY;
			rdata  <= 32'h00000000;
			if (araddr[11:10] != 2'b00) begin
				rresp <= pm_pkg::RESP_SLVERR;
			end else if (rd_idx == pm_pkg::POWER_CONTROL_IDX) begin
				rdata[1:0] <= power_control_reg;
			end else if (rd_idx == pm_pkg::CLOCK_STOP_IDX) begin
				rdata[pm_pkg::HALT_BIT] <= clock_stop_reg;
			end else if (rd_idx == pm_pkg::SLOW_CTRL_IDX) begin
				rdata[4:0] <= {busy, slow_domain_control_reg};
			end else if (rd_idx == pm_pkg::STATUS_IDX) begin
				rdata[3:0] <= last_wake;
			end else begin
				rresp <= pm_pkg::RESP_SLVERR;
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_run_end(logic b);
		state == pm_pkg::ST_RUN && instr_done && b && !wdog_rise;
	endsequence

	property p_idle_entry;
		s_run_end(power_control_reg == 2'b01 && !clock_stop_reg)
			|=> state == pm_pkg::ST_IDLE ##1 cpu_hold && core_clk_en;
	endproperty
	a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

	property p_idle_exit;
		state == pm_pkg::ST_IDLE && irq_pending && !wdog_rise
			|=> !power_control_reg[pm_pkg::IDLE_BIT] && state == pm_pkg::ST_RUN ##1 !cpu_hold;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle exit wrong");

	property p_stop_stays;
		state == pm_pkg::ST_STOP && !wdog_rise |=> state == pm_pkg::ST_STOP;
	endproperty
	a_stop_stays: assert property (p_stop_stays) else $error("stop left");

	property p_wdog;
		wdog_rise && state != pm_pkg::ST_BOOT
			|=> state == pm_pkg::ST_RESET_WAIT && cpu_reset && clock_stop_reg == 1'b0
				&& power_control_reg == 2'b00 && reset_vector == 16'h0000;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog reset missed");

	property p_pd_entry;
		s_run_end(clock_stop_reg) |=> state == pm_pkg::ST_SHUTDOWN
			##1 !core_clk_en && state == pm_pkg::ST_POWER_DOWN ##1 !regulator_en || wake_ok;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power-down entry wrong");

	property p_halt_clear;
		state == pm_pkg::ST_POWER_DOWN && wake_ok && !wdog_rise
			|=> !clock_stop_reg && state == pm_pkg::ST_WAKE;
	endproperty
	a_halt_clear: assert property (p_halt_clear) else $error("halt bit kept");

	property p_paths;
		state == pm_pkg::ST_POWER_DOWN |-> wake_path_en && !irq_path_en;
	endproperty
	a_paths: assert property (p_paths) else $error("pin paths overlap");

	property p_capture;
		state == pm_pkg::ST_POWER_DOWN && pin_wake[0] && !wdog_rise
			|=> pin_irq_capture[0] ##1 (pin_irq_capture[0] || $past(irq_ack[0]));
	endproperty
	a_capture: assert property (p_capture) else $error("pin wake not captured");

	// slow ticks seen in wake, then crystal cycles after the last of them
	logic [2:0] wake_ticks;
	logic [6:0] wake_cyc;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_ticks <= 3'h0;
			wake_cyc   <= 7'h00;
		end else if (state != pm_pkg::ST_WAKE) begin
			wake_ticks <= 3'h0;
			wake_cyc   <= 7'h00;
		end else if (wake_ticks < 3'h3) begin
			wake_ticks <= wake_ticks + {2'h0, slow_tick};
		end else begin
			wake_cyc <= wake_cyc + 7'h01;
		end
	end

	property p_wake_time;
		state == pm_pkg::ST_WAKE |-> wake_cyc <= {1'b0, pm_pkg::WAKE_XTAL} + 7'h01;
	endproperty
	a_wake_time: assert property (p_wake_time) else $error("wake timer overrun");
endmodule

// >>> pm_partner.sv
// far-side model: core, wake pins, timer, watchdog and slow oscillator
// assumes the bench commands interrupt, pin, timer and watchdog levels
`timescale 1ns/10ps
module pm_partner (
	input  wire logic       clk,
	input  wire logic       cpu_hold,
	input  wire logic       run,
	input  wire logic       irq_req,
	input  wire logic [1:0] pin_low,
	input  wire logic       tmr_req,
	input  wire logic       wdog_req,
	output logic            instr_done,
	output logic            irq_pending,
	output pm_pkg::wake_s   wake_raw,
	output logic            slow_wake_oscillator
);
	logic [1:0] ph;
	// slow oscillator runs free, also in power-down
	initial begin
		slow_wake_oscillator = 1'h0;
		forever #65 slow_wake_oscillator = ~slow_wake_oscillator;
	end
	// core ends an instruction every fourth cycle while run is set and not held
	initial begin
		ph = 2'h0;
		instr_done = 1'h0;
	end
	always @(posedge clk) begin
		ph <= ph + 2'h1;
		instr_done <= run && !cpu_hold && ph == 2'h3;
	end
	assign irq_pending = irq_req;
	// pins pulled high unless driven low
	assign wake_raw = {wdog_req, tmr_req, !pin_low[1], !pin_low[0]};
endmodule

// >>> testbench.sv
// self-checking bench for the power mode controller
// assumes the partner model on the far side and an AXI4-Lite master here
`timescale 1ns/10ps
module testbench;
	localparam int SLOW_NS = 130;
	localparam int LIMIT   = 30000;
	logic          clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic          arvalid, arready, rvalid, rready, instr_done, irq_pending;
	logic          slow_wake_oscillator, slow_busy, cpu_hold, cpu_reset, core_clk_en;
	logic          regulator_en, irq_path_en, wake_path_en, run, irq_req, tmr_req, wdog_req;
	logic [11:0]   awaddr, araddr;
	logic [31:0]   wdata, rdata, seed, d;
	logic [3:0]    wstrb, slow_domain_control_reg;
	logic [1:0]    bresp, rresp, irq_ack, port0_alt_function, pin_low, pin_irq_capture, r;
	logic [15:0]   reset_vector;
	pm_pkg::wake_s wake_raw;
	int            miscompares, total_checks, cyc, n;

	power_mode_control power_mode_control_inst (
		.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .instr_done, .irq_pending, .irq_ack, .wake_raw, .port0_alt_function,
		.slow_wake_oscillator, .slow_busy, .cpu_hold, .cpu_reset, .reset_vector,
		.core_clk_en, .regulator_en, .irq_path_en, .wake_path_en, .pin_irq_capture,
		.slow_domain_control_reg
	);
	pm_partner pm_partner_inst (
		.clk, .cpu_hold, .run, .irq_req, .pin_low, .tmr_req, .wdog_req, .instr_done,
		.irq_pending, .wake_raw, .slow_wake_oscillator
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction
	// bounds in clk cycles for slow cycles plus crystal cycles
	function automatic int lo(input int s, input int x);
		return (s - 1) * SLOW_NS / 8 + x;
	endfunction
	function automatic int hi(input int s, input int x);
		return (s + 1) * SLOW_NS / 8 + x + 12;
	endfunction

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %0h seen %0h", s, e, g);
			miscompares++;
		end
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(posedge clk); while (awready !== 1'h1 || wready !== 1'h1);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(posedge clk); while (bvalid !== 1'h1);
		rs = bresp;
		bready <= 1'h0;
		@(posedge clk);
	endtask
	task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge clk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge clk); while (rvalid !== 1'h1);
		v = rdata;
		rs = rresp;
		rready <= 1'h0;
		@(posedge clk);
	endtask
	// w: 0 cpu_hold, 1 cpu_reset, 2 regulator_en
	task automatic wait_sig(input int w, input logic v, output int k);
		k = 0;
		while ((w == 0 ? cpu_hold : w == 1 ? cpu_reset : regulator_en) !== v && k < 600) begin
			@(posedge clk);
			k++;
		end
	endtask
	task automatic wait_not_busy;
		for (int i = 0; i < 20; i++) begin
			axr(ba(pm_pkg::SLOW_CTRL_IDX), d, r);
			if (d[pm_pkg::BUSY_BIT] === 1'h0)
				break;
		end
		chk("busy clear", 32'h0, d[pm_pkg::BUSY_BIT]);
	endtask
	task automatic wdog_cycle(input string s);
		wdog_req <= 1'h1;
		wait_sig(1, 1'h1, n);
		chk("watchdog reset start", 32'h1, cpu_reset);
		wdog_req <= 1'h0;
		wait_sig(0, 1'h0, n);
		chk(s, 32'h1, n >= lo(12, 24) && n <= hi(12, 24));
		chk("reset vector", 32'h0, reset_vector);
		axr(ba(pm_pkg::POWER_CONTROL_IDX), d, r);
		chk("power control after watchdog", 32'h0, d);
		axr(ba(pm_pkg::CLOCK_STOP_IDX), d, r);
		chk("clock stop after watchdog", 32'h0, d);
		done(s);
	endtask

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			miscompares++;
			end_sim;
		end
	end

	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, slow_busy} = 7'h0;
		{run, irq_req, tmr_req, wdog_req} = 4'h0;
		{awaddr, araddr, wdata} = 56'h0;
		wstrb = 4'hF;
		{irq_ack, port0_alt_function, pin_low} = 6'h0;
		seed = 32'h382B9B77;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		run <= 1'h1;
		wait_sig(0, 1'h0, n);
		chk("power-on startup", 32'h1, n >= lo(14, 24) && n <= hi(14, 24));
		chk("reset vector", 32'h0, reset_vector);
		axr(12'h004, d, r);
		chk("unmapped read", pm_pkg::RESP_SLVERR, r);
		axw(12'hC1C, 32'h1, r);
		chk("aliased write", pm_pkg::RESP_SLVERR, r);
		repeat (12) @(posedge clk);
		chk("no idle from refused write", 32'h0, cpu_hold);
		done("reset and bus");
		// slow control: bits 3:0 stored, busy bit follows the slow domain only
		slow_busy <= 1'h1;
		seed = lfsr(seed);
		axw(ba(pm_pkg::SLOW_CTRL_IDX), seed & 32'h1F, r);
		repeat (6) @(posedge clk);
		axr(ba(pm_pkg::SLOW_CTRL_IDX), d, r);
		chk("slow control busy", {27'h0, 1'h1, seed[3:0]}, d);
		chk("slow control out", seed[3:0], slow_domain_control_reg);
		slow_busy <= 1'h0;
		wait_not_busy;
		done("slow control");
		run <= 1'h0;
		axw(ba(pm_pkg::POWER_CONTROL_IDX), 32'h1, r);
		repeat (8) @(posedge clk);
		chk("idle waits for instruction end", 32'h0, cpu_hold);
		run <= 1'h1;
		wait_sig(0, 1'h1, n);
		chk("idle entry", 32'h1, n < 12);
		seed = lfsr(seed);
		repeat (seed[4:0]) @(posedge clk);
		chk("idle clock runs", 32'h3, {core_clk_en, regulator_en});
		irq_req <= 1'h1;
		wait_sig(0, 1'h0, n);
		irq_req <= 1'h0;
		chk("idle interrupt exit", 32'h1, n < 10);
		axr(ba(pm_pkg::POWER_CONTROL_IDX), d, r);
		chk("idle bit cleared", 32'h0, d);
		done("idle");
		// stop only used to show its exit; software prefers power-down
		axw(ba(pm_pkg::POWER_CONTROL_IDX), 32'h2, r);
		wait_sig(0, 1'h1, n);
		chk("stop entry", 32'h1, n < 12);
		irq_req <= 1'h1;
		repeat (40) @(posedge clk);
		chk("stop ignores interrupt", 32'h3, {cpu_hold, core_clk_en});
		irq_req <= 1'h0;
		wdog_cycle("watchdog from stop");
		for (int k = 0; k < 3; k++) begin
			wait_not_busy;
			axw(ba(pm_pkg::CLOCK_STOP_IDX), 32'h2, r);
			wait_sig(2, 1'h0, n);
			chk("power-down entry", 32'h1, n < 12);
			chk("power-down clock off", 32'h1, {core_clk_en, cpu_hold});
			chk("power-down paths", 32'h1, {irq_path_en, wake_path_en});
			port0_alt_function <= 2'h0;
			pin_low <= 2'h3;
			repeat (40) @(posedge clk);
			chk("disabled pin no wake", 32'h0, regulator_en);
			pin_low <= 2'h0;
			seed = lfsr(seed);
			repeat (8 + seed[3:0]) @(posedge clk);
			port0_alt_function <= 2'h3;
			if (k < 2)
				pin_low[k] <= 1'h1;
			else
				tmr_req <= 1'h1;
			wait_sig(0, 1'h0, n);
			chk("wake time", 32'h1, n >= lo(3, 0) && n <= hi(k < 2 ? 4 : 3, 52));
			pin_low <= 2'h0;
			tmr_req <= 1'h0;
			repeat (6) @(posedge clk);
			chk("wake capture", k < 2 ? 2'h1 << k : 2'h0, pin_irq_capture);
			chk("powered-up paths", 32'h2, {irq_path_en, wake_path_en});
			axr(ba(pm_pkg::CLOCK_STOP_IDX), d, r);
			chk("halt bit cleared", 32'h0, d);
			irq_ack <= 2'h3;
			@(posedge clk);
			irq_ack <= 2'h0;
			@(posedge clk);
			chk("capture cleared", 32'h0, pin_irq_capture);
			done("power-down wake");
		end
		wait_not_busy;
		axw(ba(pm_pkg::CLOCK_STOP_IDX), 32'h2, r);
		wait_sig(2, 1'h0, n);
		chk("power-down entry", 32'h0, regulator_en);
		wdog_cycle("watchdog from power-down");
		end_sim;
	end
endmodule
